// ==== design/nmt_pkg.sv ====
package nmt_pkg;

  // own network management states
  typedef enum logic [1:0] {
    ST_INIT,
    ST_PREOP,
    ST_OPER,
    ST_STOP
  } nmt_state_t;

  // i/o image: control or status word heads each direction
  localparam int IMAGE_BYTES = 512;
  localparam int WORD_BYTES  = 2;
  localparam int DATA_BYTES  = IMAGE_BYTES - WORD_BYTES;

  // control byte 0 and byte 1 layout inside the 16-bit word
  localparam int TOGGLE_BIT = 7;
  localparam int CMD_HI     = 6;
  localparam int CMD_LO     = 4;
  localparam int EXT_HI     = 3;
  localparam int EXT_LO     = 0;
  localparam int NODE_HI    = 15;
  localparam int NODE_LO    = 8;

  // command codes
  localparam logic [2:0] CMD_SET_STATE = 3'h0;
  localparam logic [2:0] CMD_GET_STATE = 3'h1;
  localparam logic [2:0] CMD_GEN_STAT  = 3'h2;
  localparam logic [2:0] CMD_NOP       = 3'h7;

  // command extensions and state answers
  localparam logic [3:0] EXT_PREOP    = 4'h0;
  localparam logic [3:0] EXT_OPER     = 4'h1;
  localparam logic [3:0] EXT_RST_NODE = 4'h2;
  localparam logic [3:0] EXT_RST_COMM = 4'h3;
  localparam logic [3:0] EXT_STOP     = 4'h4;
  localparam logic [3:0] EXT_UNKNOWN  = 4'h5;
  localparam logic [3:0] EXT_MISSING  = 4'h6;
  localparam logic [3:0] EXT_ERROR    = 4'hf;

  // target node numbers
  localparam logic [7:0] NODE_SELF = 8'h00;
  localparam logic [7:0] NODE_ALL  = 8'h80;

  localparam logic [15:0] EMCY_NOT_ALLOWED = 16'hff10;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_STAT  = 8'h04;
  localparam logic [7:0] OFF_CFG   = 8'h08;
  localparam logic [7:0] OFF_STATE = 8'h0c;
  localparam logic [7:0] OFF_NODE  = 8'h10;
  localparam logic [7:0] OFF_LOCAL = 8'h14;

  // configuration register fields
  localparam int CFG_SLAVE    = 0;
  localparam int CFG_STORED   = 1;
  localparam int CFG_DEFAULTS = 2;
  localparam int CFG_GEN_LO   = 4;

  // node table write fields
  localparam int NODE_ST_LO = 8;
  localparam int NODE_SUP   = 12;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // initialization time
  localparam int CLK_NS      = 10;
  localparam int INIT_NS     = 1000;
  localparam int INIT_CYCLES = (INIT_NS + CLK_NS - 1) / CLK_NS;

  typedef struct packed {
    logic       valid;
    logic [7:0] node;
    logic [3:0] ext;
  } nmt_req_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] code;
  } emcy_t;

endpackage

// ==== design/param_loader.sv ====
`timescale 1ns/1ps
module param_loader import nmt_pkg::*; #(
  parameter int CYCLES = INIT_CYCLES
) (
  // clock and reset
  input  logic aclk,
  input  logic aresetn,
  // request
  input  logic start,
  input  logic force_defaults,
  input  logic stored_present,
  // result
  output logic done,
  output logic use_defaults
);

  typedef struct packed {
    logic        busy;
    logic [15:0] cnt;
    logic        done;
    logic        dflt;
  } ld_t;

  ld_t s_q;
  ld_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (start) begin
      s_d.busy = 1'b1;
      s_d.cnt  = 16'(CYCLES - 1);
      s_d.dflt = force_defaults | ~stored_present;
    end else if (s_q.busy) begin
      if (s_q.cnt == 16'h0000) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign done         = s_q.done;
  assign use_defaults = s_q.dflt;

endmodule // param_loader

// ==== design/nmt_command_control.sv ====
// What this block does
// - power-on enters initialization; stored parameters, else defaults; restore forces defaults
// - initialization finished moves automatically to pre-operational, no i/o exchange
// - i/o data exchange only while operational
// - stopped halts communication except guarding and heartbeat; any transition allowed
// - state changes on management request, hardware reset or local control
// - 512-byte image per direction, first two bytes control or status word
// - new command only when toggle bit changes on a control word write
// - byte 0 is toggle, 3-bit command, 4-bit extension; byte 1 node
// - node 0 is the module, 80h all nodes, else that node
// - command 0 sets state: preop, operational, reset node, reset comm, stop
// - slave role state follows the plc; pre-operational by default
// - command 1 returns stored state of supervised nodes
// - command 2 returns general status of the fieldbus interface
// - command 7 does nothing; commands 3 to 6 reserved
// - secondary start refused with emergency ff10h unless plc allowed operational
// - same emergency when the plc returns the module to pre-operational
// - master manages secondary net once operational; slave answers secondary master
// - reset node restores downloaded configuration and reinitializes
// - reset communication restores communication settings and reinitializes
// - status byte 0 echoes last valid command; byte 1 lowest failing node
// - status byte 0 msb mirrors the control toggle bit; the code copies it only when a command is echoed, else it keeps the old value
`timescale 1ns/1ps
module nmt_command_control import nmt_pkg::*; #(
  parameter int NODES       = 128,
  parameter int INIT_CYCLES_P = INIT_CYCLES
) (
  // clock and reset
  input  logic        aclk,
  input  logic        aresetn,
  // axi4-lite write address
  input  logic [7:0]  s_axi_awaddr,
  input  logic        s_axi_awvalid,
  output logic        s_axi_awready,
  // axi4-lite write data
  input  logic [31:0] s_axi_wdata,
  input  logic [3:0]  s_axi_wstrb,
  input  logic        s_axi_wvalid,
  output logic        s_axi_wready,
  // axi4-lite write response
  output logic [1:0]  s_axi_bresp,
  output logic        s_axi_bvalid,
  input  logic        s_axi_bready,
  // axi4-lite read
  input  logic [7:0]  s_axi_araddr,
  input  logic        s_axi_arvalid,
  output logic        s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0]  s_axi_rresp,
  output logic        s_axi_rvalid,
  input  logic        s_axi_rready,
  // primary network and secondary network events
  input  logic        plc_running,
  input  logic        sec_start_req,
  output logic        sec_start_ack,
  output nmt_req_t    nmt_req,
  output emcy_t       emcy,
  // module state
  output nmt_state_t  own_state,
  output logic        io_exchange_en,
  output logic        guarding_en,
  output logic        params_default,
  output logic        comm_only_reset
);

  typedef struct packed {
    nmt_state_t  nmt;
    logic [15:0] ctrl;
    logic        tog_seen;
    logic        pend;
    logic [7:0]  status0;
    logic        slave;
    logic        stored;
    logic [3:0]  gen;
    logic        allow_op;
    logic        init_start;
    logic        init_dflt;
    logic        comm_only;
    logic        awready;
    logic        aw_hold;
    logic [7:0]  awaddr;
    logic        wready;
    logic        w_hold;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        sec_ack;
    nmt_req_t    req;
    emcy_t       emcy;
    logic        io_en;
    logic        guard;
    logic [7:0]  emcy_cnt;
    logic        tbl_we;
    logic [6:0]  tbl_idx;
    logic [3:0]  tbl_st;
    logic        tbl_sup;
    logic [6:0]  scan;
    logic [6:0]  best;
    logic [6:0]  lowest;
  } st_t;

  st_t s_q;
  st_t s_d;

  // secondary node table, written by software from guarding results
  logic [3:0] tbl_state [NODES];
  logic       tbl_sup   [NODES];

  logic init_done;
  logic use_dflt;

  param_loader #(
    .CYCLES (INIT_CYCLES_P)
  ) u_loader (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .start          (s_q.init_start),
    .force_defaults (s_q.init_dflt),
    .stored_present (s_q.stored),
    .done           (init_done),
    .use_defaults   (use_dflt)
  );

  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  function automatic logic [3:0] state_code(input nmt_state_t s);
    case (s)
      ST_PREOP: state_code = EXT_PREOP;
      ST_OPER:  state_code = EXT_OPER;
      ST_STOP:  state_code = EXT_STOP;
      default:  state_code = EXT_UNKNOWN;
    endcase
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a, input st_t s);
    rd_word = 32'h0000_0000;
    if (is_reg(a, OFF_CTRL)) begin
      rd_word[15:0] = s.ctrl;
    end else if (is_reg(a, OFF_STAT)) begin
      rd_word[15:0] = {1'b0, s.lowest, s.status0};
    end else if (is_reg(a, OFF_CFG)) begin
      rd_word[CFG_SLAVE]               = s.slave;
      rd_word[CFG_STORED]              = s.stored;
      rd_word[CFG_GEN_LO+3:CFG_GEN_LO] = s.gen;
    end else if (is_reg(a, OFF_STATE)) begin
      rd_word[15:0] = {s.emcy_cnt, 1'b0, s.guard, s.allow_op, s.io_en, state_code(s.nmt)};
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return is_reg(a, OFF_CTRL) | is_reg(a, OFF_STAT) | is_reg(a, OFF_CFG)
         | is_reg(a, OFF_STATE) | is_reg(a, OFF_NODE) | is_reg(a, OFF_LOCAL);
  endfunction

  always_comb begin
    logic [2:0] cmd;
    logic [3:0] ext;
    logic [7:0] node;
    logic [3:0] rext;
    logic       echo;
    logic       own_v;
    logic [3:0] own_ext;
    logic [15:0] nc;
    logic       hit;
    cmd     = s_q.ctrl[CMD_HI:CMD_LO];
    ext     = s_q.ctrl[EXT_HI:EXT_LO];
    node    = s_q.ctrl[NODE_HI:NODE_LO];
    rext    = ext;
    echo    = 1'b0;
    own_v   = 1'b0;
    own_ext = ext;
    nc      = s_q.ctrl;
    hit     = 1'b0;
    s_d            = s_q;
    s_d.init_start = 1'b0;
    s_d.sec_ack    = 1'b0;
    s_d.req.valid  = 1'b0;
    s_d.emcy.valid = 1'b0;
    s_d.tbl_we     = 1'b0;

    // write channel: address and data taken in either order
    if (s_q.awready && s_axi_awvalid) begin
      s_d.awready = 1'b0;
      s_d.aw_hold = 1'b1;
      s_d.awaddr  = s_axi_awaddr;
    end
    if (s_q.wready && s_axi_wvalid) begin
      s_d.wready = 1'b0;
      s_d.w_hold = 1'b1;
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid  = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
    end

    // command execution waits while the module is initializing
    if (s_q.pend && s_q.nmt != ST_INIT) begin
      s_d.pend = 1'b0;
      case (cmd)
        CMD_SET_STATE: begin
          if (ext > EXT_STOP) begin
            echo = 1'b0;
          end else if (node == NODE_SELF) begin
            echo    = 1'b1;
            own_v   = 1'b1;
            own_ext = ext;
          end else if (!s_q.slave && s_q.nmt == ST_OPER) begin
            echo         = 1'b1;
            s_d.req.valid = 1'b1;
            s_d.req.node  = node;
            s_d.req.ext   = ext;
          end
        end
        CMD_GET_STATE: begin
          echo = 1'b1;
          if (node == NODE_SELF || node == NODE_ALL) begin
            rext = state_code(s_q.nmt);
          end else if (node < NODE_ALL && tbl_sup[node[6:0]]) begin
            rext = tbl_state[node[6:0]];
          end else begin
            rext = EXT_UNKNOWN;
          end
        end
        CMD_GEN_STAT: begin
          echo = 1'b1;
          rext = s_q.gen;
        end
        CMD_NOP: echo = 1'b1;
        default: echo = 1'b0;
      endcase
      if (echo) begin
        s_d.status0 = {s_q.ctrl[TOGGLE_BIT], cmd, rext};
      end
    end

    // register writes once both halves are held
    if (s_q.aw_hold && s_q.w_hold) begin
      s_d.aw_hold = 1'b0;
      s_d.w_hold  = 1'b0;
      s_d.bvalid  = 1'b1;
      hit         = mapped(s_q.awaddr);
      s_d.bresp   = hit ? RESP_OKAY : RESP_SLVERR;
      if (is_reg(s_q.awaddr, OFF_CTRL)) begin
        if (s_q.wstrb[0]) begin
          nc[7:0] = s_q.wdata[7:0];
        end
        if (s_q.wstrb[1]) begin
          nc[15:8] = s_q.wdata[15:8];
        end
        s_d.ctrl = nc;
        if (nc[TOGGLE_BIT] != s_q.tog_seen) begin
          s_d.tog_seen = nc[TOGGLE_BIT];
          s_d.pend     = 1'b1;
        end
      end else if (is_reg(s_q.awaddr, OFF_CFG) && s_q.wstrb[0]) begin
        s_d.slave  = s_q.wdata[CFG_SLAVE];
        s_d.stored = s_q.wdata[CFG_STORED];
        s_d.gen    = s_q.wdata[CFG_GEN_LO+3:CFG_GEN_LO];
        if (s_q.wdata[CFG_DEFAULTS]) begin
          s_d.nmt        = ST_INIT;
          s_d.init_start = 1'b1;
          s_d.init_dflt  = 1'b1;
          s_d.comm_only  = 1'b0;
          s_d.allow_op   = 1'b0;
        end
      end else if (is_reg(s_q.awaddr, OFF_NODE)) begin
        s_d.tbl_we  = 1'b1;
        s_d.tbl_idx = s_q.wdata[6:0];
        s_d.tbl_st  = s_q.wdata[NODE_ST_LO+3:NODE_ST_LO];
        s_d.tbl_sup = s_q.wdata[NODE_SUP];
      end else if (is_reg(s_q.awaddr, OFF_LOCAL) && !own_v && s_q.nmt != ST_INIT) begin
        own_v   = s_q.wdata[EXT_HI:EXT_LO] <= EXT_STOP;
        own_ext = s_q.wdata[EXT_HI:EXT_LO];
      end
    end

    // own state request from the control word or local control
    if (own_v) begin
      case (own_ext)
        EXT_OPER: begin
          s_d.allow_op = 1'b1;
          if (!s_q.slave) begin
            s_d.nmt = ST_OPER;
          end
        end
        EXT_PREOP: begin
          if (s_q.allow_op || s_q.nmt == ST_OPER) begin
            s_d.emcy.valid = 1'b1;
            s_d.emcy.code  = EMCY_NOT_ALLOWED;
          end
          s_d.allow_op = 1'b0;
          s_d.nmt      = ST_PREOP;
        end
        EXT_STOP: s_d.nmt = ST_STOP;
        default: begin
          s_d.nmt        = ST_INIT;
          s_d.allow_op   = 1'b0;
          s_d.init_start = 1'b1;
          s_d.init_dflt  = 1'b0;
          s_d.comm_only  = own_ext == EXT_RST_COMM;
        end
      endcase
    end

    // slave role: the plc and the secondary master decide together
    if (s_q.slave && !s_d.init_start) begin
      if (!plc_running && s_d.nmt == ST_OPER) begin
        s_d.nmt = ST_PREOP;
      end
      if (sec_start_req && s_d.nmt != ST_INIT) begin
        if (s_d.allow_op && plc_running) begin
          s_d.nmt     = ST_OPER;
          s_d.sec_ack = 1'b1;
        end else begin
          s_d.emcy.valid = 1'b1;
          s_d.emcy.code  = EMCY_NOT_ALLOWED;
        end
      end
    end

    if (s_q.nmt == ST_INIT && init_done && !s_d.init_start) begin
      s_d.nmt = ST_PREOP;
    end
    if (s_d.emcy.valid) begin
      s_d.emcy_cnt = s_q.emcy_cnt + 8'h01;
    end
    s_d.io_en = s_d.nmt == ST_OPER;
    s_d.guard = s_d.nmt != ST_INIT;

    // read channel
    if (s_q.arready && s_axi_arvalid) begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rdata   = rd_word(s_axi_araddr, s_q);
      s_d.rresp   = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end

    // background walk finds the lowest failing node
    s_d.scan = s_q.scan + 7'h01;
    if (s_q.scan != 7'h00 && s_q.best == 7'h00 && tbl_sup[s_q.scan]
        && (tbl_state[s_q.scan] == EXT_ERROR || tbl_state[s_q.scan] == EXT_MISSING)) begin
      s_d.best = s_q.scan;
    end
    if (s_q.scan == 7'(NODES - 1)) begin
      s_d.lowest = s_d.best;
      s_d.best   = 7'h00;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q            <= '0;
      s_q.nmt        <= ST_INIT;
      s_q.init_start <= 1'b1;
      s_q.awready    <= 1'b1;
      s_q.wready     <= 1'b1;
      s_q.arready    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // unsupervised nodes never report errors
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NODES; i++) begin
        tbl_sup[i]   <= 1'b0;
        tbl_state[i] <= EXT_UNKNOWN;
      end
    end else if (s_q.tbl_we) begin
      tbl_sup[s_q.tbl_idx]   <= s_q.tbl_sup;
      tbl_state[s_q.tbl_idx] <= s_q.tbl_st;
    end
  end

  assign s_axi_awready   = s_q.awready;
  assign s_axi_wready    = s_q.wready;
  assign s_axi_bresp     = s_q.bresp;
  assign s_axi_bvalid    = s_q.bvalid;
  assign s_axi_arready   = s_q.arready;
  assign s_axi_rdata     = s_q.rdata;
  assign s_axi_rresp     = s_q.rresp;
  assign s_axi_rvalid    = s_q.rvalid;
  assign sec_start_ack   = s_q.sec_ack;
  assign nmt_req         = s_q.req;
  assign emcy            = s_q.emcy;
  assign own_state       = s_q.nmt;
  assign io_exchange_en  = s_q.io_en;
  assign guarding_en     = s_q.guard;
  assign params_default  = use_dflt;
  assign comm_only_reset = s_q.comm_only;

endmodule // nmt_command_control

// ==== bench/nmt_far_side.sv ====
`timescale 1ns/1ps
module nmt_far_side import nmt_pkg::*; (
  // clock
  input  logic aclk,
  // primary plc and secondary master
  output logic plc_running,
  output logic sec_start_req
);
  logic toggle_q = 1'b0;
  logic slave_q  = 1'b0;

  initial begin
    plc_running   = 1'b0;
    sec_start_req = 1'b0;
  end

  task automatic set_role(input logic slave, input logic clr);
    slave_q = slave;
    if (clr) toggle_q = 1'b0;
  endtask

  // every new command flips the toggle; node forced to 0 as slave
  task automatic next_word(input logic [2:0] c, input logic [3:0] e, input logic [7:0] n,
                           output logic [31:0] w);
    toggle_q = ~toggle_q;
    w = {16'h0, (slave_q ? NODE_SELF : n), toggle_q, c, e};
  endtask

  task automatic set_plc(input logic run);
    @(posedge aclk);
    plc_running <= run;
  endtask

  task automatic ask_start;
    @(posedge aclk);
    sec_start_req <= 1'b1;
    @(posedge aclk);
    sec_start_req <= 1'b0;
  endtask
endmodule // nmt_far_side

// ==== bench/nmt_command_control_checker.sv ====
`timescale 1ns/1ps
module nmt_command_control_checker import nmt_pkg::*; #(
  parameter int INIT_CYCLES_P = INIT_CYCLES
) (
  // clock and reset
  input logic       aclk,
  input logic       aresetn,
  // write channels
  input logic       s_axi_awvalid,
  input logic       s_axi_awready,
  input logic       s_axi_wvalid,
  input logic       s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic       s_axi_bvalid,
  input logic       s_axi_bready,
  // events and state
  input logic       plc_running,
  input logic       sec_start_req,
  input logic       sec_start_ack,
  input nmt_req_t   nmt_req,
  input emcy_t      emcy,
  input nmt_state_t own_state,
  input logic       io_exchange_en,
  input logic       guarding_en
);
  // slack covers loader handshake around the init count
  localparam int INIT_MAX = INIT_CYCLES_P + 8;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence init_left;
    $past(own_state) == ST_INIT && own_state != ST_INIT;
  endsequence

  a_io_only_oper: assert property (io_exchange_en == (own_state == ST_OPER))
    else $error("io exchange outside operational");
  a_guard_not_init: assert property (guarding_en == (own_state != ST_INIT))
    else $error("guarding wrong for state");
  a_init_to_preop: assert property (init_left |-> own_state == ST_PREOP)
    else $error("init left to wrong state");
  a_init_bounded: assert property (
    $rose(own_state == ST_INIT) |-> ##[1:INIT_MAX] own_state == ST_PREOP)
    else $error("init did not finish");
  a_emcy_code: assert property (emcy.valid |-> emcy.code == EMCY_NOT_ALLOWED)
    else $error("wrong emergency code");
  a_bresp_timing: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  a_bvalid_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_ack_caused: assert property (
    sec_start_ack |-> $past(sec_start_req) && $past(plc_running))
    else $error("start granted without cause");
  a_req_pulse: assert property (nmt_req.valid |=> !nmt_req.valid)
    else $error("set-state request too long");
  a_remote_node: assert property (
    nmt_req.valid |-> nmt_req.node != NODE_SELF && nmt_req.ext <= EXT_STOP)
    else $error("bad remote request");
endmodule // nmt_command_control_checker

bind nmt_command_control nmt_command_control_checker #(.INIT_CYCLES_P(INIT_CYCLES_P)) u_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .plc_running, .sec_start_req, .sec_start_ack, .nmt_req, .emcy,
  .own_state, .io_exchange_en, .guarding_en);

// ==== bench/gateway_nmt_command_control_tb_top.sv ====
`timescale 1ns/1ps
module gateway_nmt_command_control_tb_top import nmt_pkg::*; ;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        plc_running, sec_start_req, sec_start_ack;
  logic        io_exchange_en, guarding_en, params_default, comm_only_reset;
  nmt_req_t    nmt_req, last_req;
  emcy_t       emcy;
  nmt_state_t  own_state, st_q;
  logic [31:0] w, d;
  int          errors = 0, n_compared = 0, n_req = 0, n_emcy = 0, n_ack = 0, n_init = 0;
  int          cycles = 0, k;

  always #5 aclk = ~aclk;

  nmt_command_control #(.NODES(128), .INIT_CYCLES_P(2)) uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .plc_running, .sec_start_req, .sec_start_ack, .nmt_req, .emcy, .own_state, .io_exchange_en,
    .guarding_en, .params_default, .comm_only_reset);
  nmt_far_side far (.aclk, .plc_running, .sec_start_req);

  // pulses stand one cycle, so they are counted at every edge
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    st_q <= own_state;
    if (nmt_req.valid === 1'b1) begin
      last_req <= nmt_req;
      n_req <= n_req + 1;
    end
    if (emcy.valid === 1'b1) n_emcy <= n_emcy + 1;
    if (sec_start_ack === 1'b1) n_ack <= n_ack + 1;
    if (own_state === ST_INIT && st_q !== ST_INIT) n_init <= n_init + 1;
    if (cycles == 20000) begin
      errors++;
      finish_test;
    end
  end

  task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] m, e);
    axi_rd(a);
    chk(n, e, d & m);
  endtask

  task automatic cmd(input logic [2:0] c, input logic [3:0] e, input logic [7:0] n);
    far.next_word(c, e, n, w);
    axi_wr(OFF_CTRL, w);
    repeat (2) @(posedge aclk);
  endtask

  task automatic wait_st(input nmt_state_t s);
    for (int i = 0; i < 60 && own_state !== s; i++) @(posedge aclk);
    #1;
    chk("own_state", {30'h0, s}, {30'h0, own_state});
  endtask

  task automatic t_boot;
    chk("reset_state", {30'h0, ST_INIT}, {30'h0, own_state});
    chk("guard_init", 32'h0, {31'h0, guarding_en});
    wait_st(ST_PREOP);
    chk("io_preop", 32'h0, {31'h0, io_exchange_en});
    chk("defaults", 32'h1, {31'h0, params_default});
    rd_chk("state_reg", OFF_STATE, 32'h5f, 32'h40);
    $display("test boot done");
  endtask

  task automatic t_set_state;
    cmd(CMD_SET_STATE, EXT_OPER, NODE_SELF);
    wait_st(ST_OPER);
    chk("io_oper", 32'h1, {31'h0, io_exchange_en});
    rd_chk("echo", OFF_STAT, 32'hff, {24'h0, w[7:0]});
    w[3:0] = EXT_STOP;
    axi_wr(OFF_CTRL, w);
    repeat (3) @(posedge aclk);
    chk("same_toggle", {30'h0, ST_OPER}, {30'h0, own_state});
    cmd(CMD_SET_STATE, EXT_STOP, NODE_SELF);
    wait_st(ST_STOP);
    chk("guard_stop", 32'h1, {31'h0, guarding_en});
    cmd(CMD_SET_STATE, EXT_OPER, NODE_SELF);
    wait_st(ST_OPER);
    k = n_emcy;
    cmd(CMD_SET_STATE, EXT_PREOP, NODE_SELF);
    wait_st(ST_PREOP);
    chk("emcy_preop", k + 1, n_emcy);
    $display("test set_state done");
  endtask

  task automatic t_remote;
    cmd(CMD_SET_STATE, EXT_OPER, NODE_SELF);
    k = n_req;
    cmd(CMD_SET_STATE, EXT_OPER, NODE_ALL);
    chk("req_all", {1'b1, NODE_ALL, EXT_OPER}, last_req);
    cmd(CMD_SET_STATE, EXT_STOP, 8'h02);
    chk("req_node", {1'b1, 8'h02, EXT_STOP}, last_req);
    wait_st(ST_OPER);
    cmd(3'h3, EXT_OPER, NODE_ALL);
    cmd(CMD_SET_STATE, 4'h5, NODE_ALL);
    chk("req_count", k + 2, n_req);
    rd_chk("kept", OFF_STAT, 32'h7f, {25'h0, CMD_SET_STATE, EXT_STOP});
    $display("test remote done");
  endtask

  task automatic t_queries;
    cmd(CMD_GET_STATE, 4'h0, NODE_SELF);
    rd_chk("get_own", OFF_STAT, 32'h7f, {25'h0, CMD_GET_STATE, EXT_OPER});
    cmd(CMD_GET_STATE, 4'h0, 8'h05);
    rd_chk("get_unsup", OFF_STAT, 32'h7f, {25'h0, CMD_GET_STATE, EXT_UNKNOWN});
    axi_wr(OFF_NODE, 32'h1405);
    cmd(CMD_GET_STATE, 4'h0, 8'h05);
    rd_chk("get_sup", OFF_STAT, 32'h7f, {25'h0, CMD_GET_STATE, EXT_STOP});
    axi_wr(OFF_CFG, 32'ha0);
    cmd(CMD_GEN_STAT, 4'h0, NODE_SELF);
    rd_chk("gen_stat", OFF_STAT, 32'h7f, {25'h0, CMD_GEN_STAT, 4'ha});
    k = n_req;
    cmd(CMD_NOP, 4'h3, NODE_ALL);
    rd_chk("nop_echo", OFF_STAT, 32'h7f, {25'h0, CMD_NOP, 4'h3});
    chk("nop_quiet", k, n_req);
    axi_wr(OFF_NODE, 32'h1f05);
    repeat (300) @(posedge aclk);
    rd_chk("fail_node", OFF_STAT, 32'h7f00, 32'h0500);
    $display("test queries done");
  endtask

  task automatic t_slave;
    cmd(CMD_SET_STATE, EXT_PREOP, NODE_SELF);
    axi_wr(OFF_CFG, 32'h1);
    far.set_role(1'b1, 1'b0);
    cmd(CMD_SET_STATE, EXT_OPER, 8'h07);
    wait_st(ST_PREOP);
    k = n_emcy;
    far.ask_start;
    repeat (3) @(posedge aclk);
    chk("refused", k + 1, n_emcy);
    far.set_plc(1'b1);
    far.ask_start;
    wait_st(ST_OPER);
    chk("granted", 32'h1, n_ack);
    far.set_plc(1'b0);
    wait_st(ST_PREOP);
    $display("test slave done");
  endtask

  task automatic t_resets;
    k = n_init;
    cmd(CMD_SET_STATE, EXT_RST_COMM, NODE_SELF);
    wait_st(ST_PREOP);
    chk("reinit_comm", k + 1, n_init);
    chk("comm_only", 32'h1, {31'h0, comm_only_reset});
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    far.set_role(1'b0, 1'b1);
    wait_st(ST_PREOP);
    axi_wr(OFF_CFG, 32'h2);
    k = n_init;
    cmd(CMD_SET_STATE, EXT_RST_NODE, NODE_SELF);
    wait_st(ST_PREOP);
    chk("reinit_node", k + 1, n_init);
    chk("node_reset", 32'h0, {31'h0, comm_only_reset});
    chk("stored_used", 32'h0, {31'h0, params_default});
    axi_wr(OFF_CFG, 32'h6);
    repeat (2) @(posedge aclk);
    wait_st(ST_PREOP);
    chk("restore", 32'h1, {31'h0, params_default});
    axi_wr(OFF_LOCAL, 32'h4);
    wait_st(ST_STOP);
    $display("test resets done");
  endtask

  task automatic t_unmapped;
    axi_wr(8'h18, 32'h1234);
    chk("wr_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd_chk("rd_data", 8'h18, 32'hffffffff, 32'h0);
    chk("rd_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    $display("test unmapped done");
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    #1;
    t_boot;
    t_set_state;
    t_remote;
    t_queries;
    t_slave;
    t_resets;
    t_unmapped;
    finish_test;
  end
endmodule // gateway_nmt_command_control_tb_top
